// ### tcc_pkg.sv
// Package with offsets, field positions, codes and types of the 16-bit timer/counter block.
`default_nettype none
package tcc_pkg;
    // Register offsets on the 8-bit I/O register port.
    localparam logic [3:0] OFF_CTRL_A  = 4'h0;
    localparam logic [3:0] OFF_CTRL_B  = 4'h1;
    localparam logic [3:0] OFF_CTRL_C  = 4'h2;
    localparam logic [3:0] OFF_CNT_L   = 4'h3;
    localparam logic [3:0] OFF_CNT_H   = 4'h4;
    localparam logic [3:0] OFF_OCRA_L  = 4'h5;
    localparam logic [3:0] OFF_OCRA_H  = 4'h6;
    localparam logic [3:0] OFF_OCRB_L  = 4'h7;
    localparam logic [3:0] OFF_OCRB_H  = 4'h8;
    localparam logic [3:0] OFF_ICR_L   = 4'h9;
    localparam logic [3:0] OFF_ICR_H   = 4'hA;
    localparam logic [3:0] OFF_MASK    = 4'hB;
    localparam logic [3:0] OFF_FLAGS   = 4'hC;

    // Reset values of the control, mask and 16-bit word registers.
    localparam logic [7:0]  CTRL_A_RESET = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET = 8'h00;
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    // Writable bits of each register; all other bits read as zero.
    localparam logic [7:0] CTRL_A_BITS = 8'hF3;
    localparam logic [7:0] CTRL_B_BITS = 8'hDF;
    localparam logic [7:0] IRQ_BITS    = 8'h27;

    // Field positions in control register B.
    localparam int unsigned POS_FILTER  = 7;
    localparam int unsigned POS_EDGE    = 6;
    localparam int unsigned POS_WAVE_HI = 4;
    localparam int unsigned POS_WAVE_LO = 3;
    // Field positions in control register C.
    localparam int unsigned POS_FORCE_A = 7;
    localparam int unsigned POS_FORCE_B = 6;
    // Bit positions shared by the mask and flag registers.
    localparam int unsigned POS_CAPT    = 5;
    localparam int unsigned POS_MATCH_B = 2;
    localparam int unsigned POS_MATCH_A = 1;
    localparam int unsigned POS_OVF     = 0;

    // Clock select codes.
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Fixed TOP values and the counter maximum.
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    // Equal samples the capture filter needs before its output moves.
    localparam int unsigned FILTER_SAMPLES = 4;

    // One access on the I/O register port.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcc_bus_t;

    // One bit per interrupt source.
    typedef struct packed {
        logic capture;
        logic match_b;
        logic match_a;
        logic overflow;
    } tcc_irq_t;

    // Counting direction of the dual-slope modes.
    typedef enum logic {TCC_COUNT_UP, TCC_COUNT_DOWN} tcc_dir_t;
endpackage
`default_nettype wire

// ### tcc_timer16.sv
// Control, counting, capture, forced-compare and interrupt logic of the 16-bit timer/counter.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16 (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire tcc_pkg::tcc_bus_t bus,
    output logic [7:0]             rdata,
    input  wire logic              global_irq_enable,
    input  wire tcc_pkg::tcc_irq_t vector_done,
    output tcc_pkg::tcc_irq_t      irq,
    input  wire logic              capture_pin,
    input  wire logic              external_count_pin,
    input  wire logic              comparator_out,
    input  wire logic              capture_from_comparator,
    output logic                   wave_output_a,
    output logic                   wave_output_b,
    output logic                   wave_enable_a,
    output logic                   wave_enable_b
);
    import tcc_pkg::*;

    // Register state.
    logic [7:0]  ctrl_a_reg;     // Compare output actions and low mode bits.
    logic [7:0]  ctrl_b_reg;     // Filter, edge, high mode bits and clock select.
    logic [7:0]  mask_reg;       // Interrupt enables.
    tcc_irq_t    flags_reg;      // Sticky event flags.
    tcc_irq_t    flags_next;
    logic [7:0]  temp_reg;       // Shared high byte latch.
    logic [15:0] cnt_reg;        // The counter.
    logic [15:0] cnt_next;
    tcc_dir_t    dir_reg;        // Direction in dual-slope modes.
    tcc_dir_t    dir_next;
    logic [15:0] ocr_reg [2];    // Compare values, index 0 is channel A.
    logic [15:0] icr_reg;        // Capture value.
    logic        block_reg;      // Set by a counter write until the next timer tick.
    logic [9:0]  presc_reg;      // Free-running prescaler.
    logic [1:0]  wave_reg;       // Waveform outputs, bit 0 is channel A.
    logic [1:0]  wave_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;

    // Synchronisers and capture path.
    logic        cap_s1_reg, cap_s2_reg;
    logic        ext_s1_reg, ext_s2_reg, ext_prev_reg;
    logic [FILTER_SAMPLES-2:0] cap_hist_reg;  // Previous samples of the synchronised pin.
    logic        cap_filt_reg;                // Filtered pin level.
    logic        cap_prev_reg;                // Previous level of the selected capture source.

    // Write strobes, one per location, with one shared by the four high bytes.
    wire wr_ctrl_a = bus.wr && (bus.addr == OFF_CTRL_A);
    wire wr_ctrl_b = bus.wr && (bus.addr == OFF_CTRL_B);
    wire wr_ctrl_c = bus.wr && (bus.addr == OFF_CTRL_C);
    wire wr_cnt_l  = bus.wr && (bus.addr == OFF_CNT_L);
    wire wr_ocra_l = bus.wr && (bus.addr == OFF_OCRA_L);
    wire wr_ocrb_l = bus.wr && (bus.addr == OFF_OCRB_L);
    wire wr_icr_l  = bus.wr && (bus.addr == OFF_ICR_L);
    wire wr_mask   = bus.wr && (bus.addr == OFF_MASK);
    wire wr_flags  = bus.wr && (bus.addr == OFF_FLAGS);
    wire wr_high   = bus.wr && ((bus.addr == OFF_CNT_H) || (bus.addr == OFF_OCRA_H) ||
                                (bus.addr == OFF_OCRB_H) || (bus.addr == OFF_ICR_H));
    wire [15:0] wr_word = {temp_reg, bus.wdata};

    wire [3:0] wave_mode = {ctrl_b_reg[POS_WAVE_HI], ctrl_b_reg[POS_WAVE_LO], ctrl_a_reg[1:0]};
    wire is_pwm     = (wave_mode != 4'h0) && (wave_mode != 4'h4) && (wave_mode != 4'hC) && (wave_mode != 4'hD);
    wire is_fast    = (wave_mode[3:2] == 2'b01 && wave_mode[1:0] != 2'b00) || (wave_mode[3:1] == 3'b111);
    wire is_phase   = is_pwm && !is_fast;
    wire icr_is_top = (wave_mode == 4'h8) || (wave_mode == 4'hA) || (wave_mode == 4'hC) || (wave_mode == 4'hE);
    wire ocr_is_top = (wave_mode == 4'h4) || (wave_mode == 4'h9) || (wave_mode == 4'hB) || (wave_mode == 4'hF);
    wire [15:0] top = icr_is_top ? icr_reg :
                      ocr_is_top ? ocr_reg[0] :
                      (wave_mode[1:0] == 2'b01) ? TOP_8BIT :
                      (wave_mode[1:0] == 2'b10) ? TOP_9BIT :
                      (wave_mode[1:0] == 2'b11) ? TOP_10BIT : CNT_MAX;

    wire [2:0] clock_select_field = ctrl_b_reg[2:0];
    wire ext_rise = ext_s2_reg && !ext_prev_reg;
    wire ext_fall = !ext_s2_reg && ext_prev_reg;
    // External pin edges count regardless of pin direction.
    wire tick = (clock_select_field == CS_DIV1) ||
                (clock_select_field == CS_DIV8 && (&presc_reg[2:0])) ||
                (clock_select_field == CS_DIV64 && (&presc_reg[5:0])) ||
                (clock_select_field == CS_DIV256 && (&presc_reg[7:0])) ||
                (clock_select_field == CS_DIV1024 && (&presc_reg[9:0])) ||
                (clock_select_field == CS_EXT_FALL && ext_fall) ||
                (clock_select_field == CS_EXT_RISE && ext_rise);

    wire cap_src = capture_from_comparator ? comparator_out : cap_filt_reg;
    // Edge select on the chosen source.
    wire cap_edge = ctrl_b_reg[POS_EDGE] ? (cap_src && !cap_prev_reg) : (!cap_src && cap_prev_reg);
    // No pin capture while the capture register is TOP.
    wire cap_event = cap_edge && !icr_is_top;
    wire cap_top_set = tick && icr_is_top && (cnt_reg == top);

    // Continuous comparison, blocked right after a counter write.
    wire [1:0] hit;
    assign hit[0] = tick && (cnt_reg == ocr_reg[0]) && !block_reg && !wr_cnt_l;
    assign hit[1] = tick && (cnt_reg == ocr_reg[1]) && !block_reg && !wr_cnt_l;
    wire top_hit = tick && (cnt_reg == top);
    // Force strobes act only outside PWM modes.
    wire [1:0] force_hit;
    assign force_hit[0] = wr_ctrl_c && bus.wdata[POS_FORCE_A] && !is_pwm;
    assign force_hit[1] = wr_ctrl_c && bus.wdata[POS_FORCE_B] && !is_pwm;

    wire ovf_set = tick && (is_phase ? (dir_reg == TCC_COUNT_DOWN && cnt_reg == WORD_RESET) :
                            is_fast  ? (cnt_reg == top) : (cnt_reg == CNT_MAX));

    // Counter sequence per mode; a software write takes precedence over a tick.
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        if (wr_cnt_l) begin
            cnt_next = wr_word;
        end else if (tick && is_phase) begin
            // Dual slope: turn at TOP and at BOTTOM.
            if (dir_reg == TCC_COUNT_UP) begin
                if (cnt_reg >= top) begin
                    dir_next = TCC_COUNT_DOWN;
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end else if (cnt_reg == WORD_RESET) begin
                dir_next = TCC_COUNT_UP;
                cnt_next = cnt_reg + 16'h0001;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (tick) begin
            // Only a real TOP match clears the counter, never a force.
            if (cnt_reg == top) begin
                cnt_next = WORD_RESET;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    // Flags: set beats clear, cleared by vector or a written one.
    always_comb begin
        flags_next.capture  = (flags_reg.capture  && !(wr_flags && bus.wdata[POS_CAPT])    && !vector_done.capture)
                              || cap_event || cap_top_set;
        flags_next.match_b  = (flags_reg.match_b  && !(wr_flags && bus.wdata[POS_MATCH_B]) && !vector_done.match_b)
                              || hit[1];
        flags_next.match_a  = (flags_reg.match_a  && !(wr_flags && bus.wdata[POS_MATCH_A]) && !vector_done.match_a)
                              || hit[0];
        flags_next.overflow = (flags_reg.overflow && !(wr_flags && bus.wdata[POS_OVF])     && !vector_done.overflow)
                              || ovf_set;
    end

    // Waveform output action of each channel.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        wire [1:0] compare_output_action = ctrl_a_reg[7-2*i -: 2];
        wire       toggle_ok = (i == 0) && wave_mode[3];
        logic      w;
        always_comb begin
            w = wave_reg[i];
            if (!is_pwm) begin
                // Non-PWM: match or force applies the selected action.
                if (hit[i] || force_hit[i]) begin
                    case (compare_output_action)
                        2'b01: w = !wave_reg[i];
                        2'b10: w = 1'b0;
                        2'b11: w = 1'b1;
                        default: w = wave_reg[i];
                    endcase
                end
            end else if (compare_output_action[1]) begin
                if (is_fast) begin
                    // Fast PWM: level at match, opposite level at TOP.
                    if (hit[i]) begin
                        w = compare_output_action[0];
                    end else if (top_hit) begin
                        w = !compare_output_action[0];
                    end
                end else if (hit[i]) begin
                    // Dual slope: level depends on direction.
                    w = (dir_reg == TCC_COUNT_UP) ? compare_output_action[0] : !compare_output_action[0];
                end
            end else if (compare_output_action[0] && toggle_ok && hit[i]) begin
                w = !wave_reg[i];
            end
        end
        assign wave_next[i] = w;
    end

    // Read mux; low byte reads also feed the shared latch.
    always_comb begin
        rdata_next = 8'h00;
        if (bus.addr == OFF_CTRL_A) begin
            rdata_next = ctrl_a_reg & CTRL_A_BITS;
        end else if (bus.addr == OFF_CTRL_B) begin
            // Reserved bit 5 is never stored, so it reads as zero.
            rdata_next = ctrl_b_reg & CTRL_B_BITS;
        end else if (bus.addr == OFF_CTRL_C) begin
            rdata_next = 8'h00;
        end else if (bus.addr == OFF_CNT_L) begin
            rdata_next = cnt_reg[7:0];
        end else if (bus.addr == OFF_OCRA_L) begin
            rdata_next = ocr_reg[0][7:0];
        end else if (bus.addr == OFF_OCRB_L) begin
            rdata_next = ocr_reg[1][7:0];
        end else if (bus.addr == OFF_ICR_L) begin
            rdata_next = icr_reg[7:0];
        end else if (bus.addr == OFF_CNT_H || bus.addr == OFF_OCRA_H ||
                     bus.addr == OFF_OCRB_H || bus.addr == OFF_ICR_H) begin
            rdata_next = temp_reg;
        end else if (bus.addr == OFF_MASK) begin
            rdata_next = mask_reg & IRQ_BITS;
        end else if (bus.addr == OFF_FLAGS) begin
            rdata_next = {2'b00, flags_reg.capture, 2'b00, flags_reg.match_b, flags_reg.match_a, flags_reg.overflow};
        end
    end

    // High byte that a low byte read latches.
    wire [7:0] latch_high = (bus.addr == OFF_CNT_L)  ? cnt_reg[15:8] :
                            (bus.addr == OFF_OCRA_L) ? ocr_reg[0][15:8] :
                            (bus.addr == OFF_OCRB_L) ? ocr_reg[1][15:8] : icr_reg[15:8];
    wire rd_low = bus.rd && ((bus.addr == OFF_CNT_L) || (bus.addr == OFF_OCRA_L) ||
                             (bus.addr == OFF_OCRB_L) || (bus.addr == OFF_ICR_L));

    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_s1_reg   <= 1'b0;
            cap_s2_reg   <= 1'b0;
            ext_s1_reg   <= 1'b0;
            ext_s2_reg   <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else if (clk_en) begin
            cap_s1_reg   <= capture_pin;
            cap_s2_reg   <= cap_s1_reg;
            ext_s1_reg   <= external_count_pin;
            ext_s2_reg   <= ext_s1_reg;
            ext_prev_reg <= ext_s2_reg;
        end
    end

    // Noise filter, bypassed when disabled; adds latency for noise immunity.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_hist_reg <= '0;
            cap_filt_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
        end else if (clk_en) begin
            cap_hist_reg <= {cap_hist_reg[FILTER_SAMPLES-3:0], cap_s2_reg};
            if (!ctrl_b_reg[POS_FILTER]) begin
                cap_filt_reg <= cap_s2_reg;
            end else if ((&cap_hist_reg) && cap_s2_reg) begin
                cap_filt_reg <= 1'b1;
            end else if (!(|cap_hist_reg) && !cap_s2_reg) begin
                cap_filt_reg <= 1'b0;
            end
            cap_prev_reg <= cap_src;
        end
    end

    // Control registers and the shared latch.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_a_reg <= CTRL_A_RESET;
            ctrl_b_reg <= CTRL_B_RESET;
            mask_reg   <= MASK_RESET;
            temp_reg   <= 8'h00;
            rdata_reg  <= 8'h00;
        end else if (clk_en) begin
            if (wr_ctrl_a) ctrl_a_reg <= bus.wdata & CTRL_A_BITS;
            if (wr_ctrl_b) ctrl_b_reg <= bus.wdata & CTRL_B_BITS;
            if (wr_mask)   mask_reg   <= bus.wdata & IRQ_BITS;
            // High write parks the byte; low read latches the high byte.
            if (wr_high) begin
                temp_reg <= bus.wdata;
            end else if (rd_low) begin
                temp_reg <= latch_high;
            end
            if (bus.rd) rdata_reg <= rdata_next;
        end
    end

    // Counter, compare, capture, flags and waveform state.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_reg    <= WORD_RESET;
            dir_reg    <= TCC_COUNT_UP;
            ocr_reg[0] <= WORD_RESET;
            ocr_reg[1] <= WORD_RESET;
            icr_reg    <= WORD_RESET;
            block_reg  <= 1'b0;
            presc_reg  <= 10'h000;
            flags_reg  <= '0;
            wave_reg   <= 2'b00;
        end else if (clk_en) begin
            presc_reg <= presc_reg + 10'h001;
            cnt_reg   <= cnt_next;
            dir_reg   <= dir_next;
            flags_reg <= flags_next;
            wave_reg  <= wave_next;
            // Hold the block until the next timer tick.
            if (wr_cnt_l) begin
                block_reg <= 1'b1;
            end else if (tick) begin
                block_reg <= 1'b0;
            end
            if (wr_ocra_l) ocr_reg[0] <= wr_word;
            if (wr_ocrb_l) ocr_reg[1] <= wr_word;
            // A capture event wins over a software write in the same cycle.
            if (cap_event) begin
                icr_reg <= cnt_reg;
            end else if (wr_icr_l) begin
                icr_reg <= wr_word;
            end
        end
    end

    assign irq.capture  = flags_reg.capture  && mask_reg[POS_CAPT]    && global_irq_enable;
    assign irq.match_b  = flags_reg.match_b  && mask_reg[POS_MATCH_B] && global_irq_enable;
    assign irq.match_a  = flags_reg.match_a  && mask_reg[POS_MATCH_A] && global_irq_enable;
    assign irq.overflow = flags_reg.overflow && mask_reg[POS_OVF]     && global_irq_enable;

    assign rdata         = rdata_reg;
    assign wave_output_a = wave_reg[0];
    assign wave_output_b = wave_reg[1];
    assign wave_enable_a = (ctrl_a_reg[7:6] != 2'b00);
    assign wave_enable_b = (ctrl_a_reg[5:4] != 2'b00);
endmodule
`default_nettype wire

// ### tcc_asserts.sv
// Concurrent checks on the timer's register port, interrupt outputs and the channel A output enable.
`timescale 1ns/1ps
`default_nettype none
module tcc_chk (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              clk_en,
    input wire tcc_pkg::tcc_bus_t bus,
    input wire logic [7:0]        rdata,
    input wire logic              global_irq_enable,
    input wire tcc_pkg::tcc_irq_t irq,
    input wire logic              wave_enable_a
);
    import tcc_pkg::*;
    // Accesses that the design takes at this edge.
    wire logic rd_ok = clk_en && bus.rd;
    wire logic wr_ok = clk_en && bus.wr;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_irq_off; !global_irq_enable |-> irq == '0; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while globally off");
    property p_ovf_gate; wr_ok && bus.addr == OFF_MASK && !bus.wdata[POS_OVF] |=> !irq.overflow; endproperty
    a_ovf_gate: assert property (p_ovf_gate) else $error("overflow irq while masked");
    property p_mask_back; wr_ok && bus.addr == OFF_MASK ##1 rd_ok && bus.addr == OFF_MASK
        |=> rdata == ($past(bus.wdata, 2) & IRQ_BITS); endproperty
    a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
    property p_force_rd; rd_ok && bus.addr == OFF_CTRL_C |=> rdata == 8'h00; endproperty
    a_force_rd: assert property (p_force_rd) else $error("force bits read nonzero");
    property p_resv_b; rd_ok && bus.addr == OFF_CTRL_B |=> !rdata[5]; endproperty
    a_resv_b: assert property (p_resv_b) else $error("control B bit 5 reads one");
    property p_resv_m; rd_ok && bus.addr == OFF_MASK |=> (rdata & ~IRQ_BITS) == 8'h00; endproperty
    a_resv_m: assert property (p_resv_m) else $error("unused mask bits read one");
    property p_hold; !rd_ok |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_wave_en; wr_ok && bus.addr == OFF_CTRL_A |=> wave_enable_a == ($past(bus.wdata[7:6]) != 2'b00);
    endproperty
    a_wave_en: assert property (p_wave_en) else $error("output enable does not follow action");
endmodule
bind tcc_timer16 tcc_chk u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .global_irq_enable(global_irq_enable), .irq(irq), .wave_enable_a(wave_enable_a));
`default_nettype wire

// ### tcc_host.sv
// Host core model that issues register accesses and notes expected read data.
`timescale 1ns/1ps
`default_nettype none
module tcc_host (
    input  wire logic         core_clk,
    output tcc_pkg::tcc_bus_t bus
);
    import tcc_pkg::*;
    // Expected reads, oldest first, each with its offset on top.
    logic [11:0] exp_q[$];
    initial bus = '0;
    // One access; the next edge takes it, so strobes never change mid-request.
    // Reserved control bit always written as zero.
    task automatic xfer(input logic [3:0] a, input logic [7:0] d, input logic w);
        bus <= '{addr: a, wdata: (w && a == OFF_CTRL_B) ? (d & CTRL_B_BITS) : d, wr: w, rd: !w};
        @(posedge core_clk);
    endtask
    // A read also notes what the monitor must see.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        xfer(a, 8'h00, 1'b0);
    endtask
    // High byte first, low byte commits.
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        xfer(lo + 4'h1, v[15:8], 1'b1);
        xfer(lo, v[7:0], 1'b1);
    endtask
    // Low byte first, so the high byte comes from the latch.
    task automatic rd16(input logic [3:0] lo, input logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask
    // Drop both strobes and let n edges pass.
    task automatic idle(input int n);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the 16-bit timer with a host model on its port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcc_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b1;
    logic        cmp = 1'b0;
    logic        csel = 1'b0;
    logic        gie = 1'b0;
    tcc_irq_t    vdone = '0;
    logic        cap_pin = 1'b1;
    logic        ext_pin = 1'b0;
    tcc_bus_t    bus;
    logic [7:0]  rdata;
    tcc_irq_t    irq;
    logic        wave_a;
    logic        wave_b;
    logic [1:0]  wen;
    logic        taken = 1'b0;
    logic [11:0] note;
    logic [15:0] v;
    int          n_fail = 0;
    int          n_tests = 0;
    int          k;
    int          n;
    int          sh[1:5] = '{0, 3, 6, 8, 10};
    always #12.5 core_clk = ~core_clk;
    tcc_host u_host (.core_clk(core_clk), .bus(bus));
    tcc_timer16 u_dut (.core_clk(core_clk), .rst(rst), .clk_en(en), .bus(bus), .rdata(rdata),
        .global_irq_enable(gie), .vector_done(vdone), .irq(irq), .capture_pin(cap_pin),
        .external_count_pin(ext_pin), .comparator_out(cmp), .capture_from_comparator(csel),
        .wave_output_a(wave_a), .wave_output_b(wave_b), .wave_enable_a(wen[0]), .wave_enable_b(wen[1]));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reads taken at a rising edge are checked at the falling edge after.
    always @(posedge core_clk) taken <= bus.rd && en && !rst;
    always @(negedge core_clk) if (taken) begin
        note = u_host.exp_q.pop_front();
        chk($sformatf("rdata at %h", note[11:8]), {8'h00, rdata}, {8'h00, note[7:0]});
    end
    // The run needs about 10600 cycles; three times that means a hang.
    initial begin
        #(25 * 32000);
        $display("Error watchdog expired");
        n_fail++;
        end_of_test();
    end
    initial begin
        k = $urandom(32'h04eb_33b3);
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Reset values, then masked and reserved bits.
        u_host.rd(OFF_CTRL_B, 8'h00);
        u_host.rd(4'hF, 8'h00);
        v = 16'($urandom);
        u_host.xfer(OFF_MASK, v[7:0], 1'b1);
        u_host.rd(OFF_MASK, v[7:0] & IRQ_BITS);
        u_host.xfer(OFF_CTRL_B, v[15:8] & 8'hD8, 1'b1);
        u_host.rd(OFF_CTRL_B, v[15:8] & 8'hD8);
        u_host.xfer(OFF_CTRL_B, 8'h00, 1'b1);
        // Force bits are set only once the random mode is cleared.
        u_host.xfer(OFF_CTRL_C, 8'hC0, 1'b1);
        u_host.rd(OFF_CTRL_C, 8'h00);
        // Every word goes through the shared latch.
        for (k = 0; k < 4; k++) begin
            v = 16'($urandom);
            u_host.wr16(4'(OFF_CNT_L + 2 * k), v);
            u_host.rd16(4'(OFF_CNT_L + 2 * k), v);
        end
        $display("registers done");
        // A 2048-cycle window holds a whole number of prescaled ticks.
        // A frozen gap in its middle must add no tick.
        for (k = 1; k < 6; k++) begin
            u_host.wr16(OFF_CNT_L, 16'h0000);
            u_host.xfer(OFF_CTRL_B, 8'(k), 1'b1);
            u_host.idle(1023);
            en <= 1'b0;
            u_host.idle($urandom_range(30, 1));
            en <= 1'b1;
            u_host.idle(1024);
            u_host.xfer(OFF_CTRL_B, 8'h00, 1'b1);
            u_host.rd16(OFF_CNT_L, 16'(2048 >> sh[k]));
        end
        $display("prescaler done");
        // Each pulse on the count pin gives one edge of either kind.
        for (k = 6; k < 8; k++) begin
            n = $urandom_range(9, 3);
            u_host.wr16(OFF_CNT_L, 16'h0000);
            u_host.xfer(OFF_CTRL_B, 8'(k), 1'b1);
            repeat (n) begin
                ext_pin <= 1'b1;
                u_host.idle(4);
                ext_pin <= 1'b0;
                u_host.idle(4);
            end
            u_host.xfer(OFF_CTRL_B, 8'h00, 1'b1);
            u_host.rd16(OFF_CNT_L, 16'(n));
        end
        $display("external clock done");
        // Only the chosen edge of the chosen source captures.
        // The second pass takes the comparator, while the pin moves the opposite way.
        gie <= 1'b1;
        u_host.xfer(OFF_MASK, 8'h20, 1'b1);
        for (k = 0; k < 2; k++) begin
            v = 16'($urandom);
            csel <= 1'(k);
            {cap_pin, cmp} <= 2'b10;
            u_host.idle(12);
            u_host.xfer(OFF_FLAGS, 8'hFF, 1'b1);
            u_host.wr16(OFF_CNT_L, v);
            u_host.xfer(OFF_CTRL_B, {1'($urandom), 1'(k), 6'h00}, 1'b1);
            {cap_pin, cmp} <= 2'b01;
            u_host.idle(12);
            u_host.wr16(OFF_CNT_L, ~v);
            {cap_pin, cmp} <= 2'b10;
            u_host.idle(12);
            u_host.rd16(OFF_ICR_L, v);
            chk("irq capture", 16'(irq.capture), 16'h0001);
            vdone.capture <= 1'b1;
            u_host.idle(1);
            vdone.capture <= 1'b0;
            u_host.idle(1);
            chk("irq after vector", 16'(irq.capture), 16'h0000);
        end
        $display("capture done");
        // Both channels flag a match unless a counter write blocks it.
        for (k = 0; k < 2; k++) begin
            v = 16'($urandom_range(16'hFF00, 16'h0100));
            u_host.wr16(OFF_OCRA_L, v);
            u_host.wr16(OFF_OCRB_L, v);
            u_host.wr16(OFF_CNT_L, v - 16'(5 - 5 * k));
            // The second pass clears channel B by a written one, channel A by vector.
            u_host.xfer(OFF_FLAGS, k ? 8'h04 : 8'hFF, 1'b1);
            vdone <= 4'(3 * k);
            u_host.xfer(OFF_CTRL_B, 8'(CS_DIV1), 1'b1);
            vdone <= '0;
            u_host.idle(9);
            u_host.xfer(OFF_CTRL_B, 8'h00, 1'b1);
            u_host.rd(OFF_FLAGS, (k == 0) ? 8'h06 : 8'h00);
        end
        $display("compare done");
        // Forcing in normal mode toggles both outputs, no flag.
        u_host.xfer(OFF_CTRL_A, 8'h50, 1'b1);
        u_host.xfer(OFF_FLAGS, 8'hFF, 1'b1);
        u_host.xfer(OFF_CTRL_C, 8'hC0, 1'b1);
        u_host.rd(OFF_FLAGS, 8'h00);
        u_host.idle(2);
        chk("wave outputs", {12'h000, wen, wave_a, wave_b}, 16'h000F);
        $display("force done");
        end_of_test();
    end
endmodule
`default_nettype wire
